// file: dwcp_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwcp_defs.svh"
// Overview of operation
// [RULE_01] Merge policy: data hit updates cache only, marks dirty; miss goes to memory.
// [RULE_02] Write-through policy: data hit updates cache and memory; miss memory only.
// [RULE_03] Bypass policy: data writes go only to memory; data cache untouched.
// [RULE_04] Data cache disabled: data writes go to memory, policy ignored.
// [RULE_05] Download writes go to memory and invalidate matching cache entries.
// [RULE_06] A write with no space given is treated as an instruction write.
// [RULE_07] Both caches disabled: instruction writes go to memory only.
// [RULE_08] Instruction cache off: memory written, data cache follows instruction policy.
// [RULE_09] Update/bypass: instruction hit updates icache and memory, dcache untouched.
// [RULE_10] Update/update: hits update both caches and memory.
// [RULE_11] Invalidate/bypass: icache hit invalidated, memory only, dcache untouched.
// [RULE_12] Invalidate/update: icache hit invalidated, memory written, dcache hit updated.
// [RULE_13] Users must beware dirty lines overwriting memory under bypassing policies.
// [RULE_14] Policy selections reset to merge data and update-both instruction policy.
module dwcp_top (
  // Clock and reset.
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // Policy configuration.
  input wire logic CFG_WE_IN,
  input wire logic [1:0] CFG_DPOL_IN,
  input wire logic [1:0] CFG_IPOL_IN,
  input wire logic IC_EN_IN,
  input wire logic DC_EN_IN,
  // Write request.
  input wire logic REQ_VALID_IN,
  input wire logic [1:0] REQ_SPACE_IN,
  input wire logic REQ_DOWNLOAD_IN,
  input wire logic IC_HIT_IN,
  input wire logic DC_HIT_IN,
  // Routing result.
  output logic ROUTE_VALID_OUT,
  output logic MEM_WR_OUT,
  output logic DC_UPD_OUT,
  output logic DC_DIRTY_OUT,
  output logic IC_UPD_OUT,
  output logic IC_INV_OUT,
  output logic DC_INV_OUT,
  // Configuration readback.
  output logic [1:0] DPOL_OUT,
  output logic [1:0] IPOL_OUT
);
  // ==========================================================
  // State.
  typedef struct packed {
    logic [1:0] dpol;
    logic [1:0] ipol;
    logic valid;
    dwcp_pkg::dwcp_route_type route;
  } dwcp_state_type;

  dwcp_state_type state_reg;
  dwcp_state_type state_next;
  dwcp_route_if rif ();

  // ==========================================================
  // Decode.
  // An untyped request falls into instruction space.
  assign rif.is_instr = (REQ_SPACE_IN != `DWCP_SPACE_DATA); // [RULE_06]
  assign rif.download = REQ_DOWNLOAD_IN;
  assign rif.ic_hit = IC_HIT_IN;
  assign rif.dc_hit = DC_HIT_IN;
  assign rif.ic_en = IC_EN_IN;
  assign rif.dc_en = DC_EN_IN;
  assign rif.dpol = state_reg.dpol;
  assign rif.ipol = state_reg.ipol;

  dwcp_decode u_dwcp_decode (
    .rif(rif)
  );

  // ==========================================================
  // Registers.
  always_comb begin
    state_next = state_reg;
    // Unused data code 3 is refused so the selection never leaves the legal set.
    if (CFG_WE_IN && (CFG_DPOL_IN != 2'h3)) begin
      state_next.dpol = CFG_DPOL_IN;
    end
    if (CFG_WE_IN) begin
      state_next.ipol = CFG_IPOL_IN;
    end
    state_next.valid = REQ_VALID_IN;
    state_next.route = REQ_VALID_IN ? rif.route : '0;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg.dpol <= `DWCP_DPOL_RESET; // [RULE_14]
      state_reg.ipol <= `DWCP_IPOL_RESET; // [RULE_14]
      state_reg.valid <= 1'b0;
      state_reg.route <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ROUTE_VALID_OUT = state_reg.valid;
  assign MEM_WR_OUT = state_reg.route.mem_wr;
  assign DC_UPD_OUT = state_reg.route.dc_upd;
  assign DC_DIRTY_OUT = state_reg.route.dc_dirty;
  assign IC_UPD_OUT = state_reg.route.ic_upd;
  assign IC_INV_OUT = state_reg.route.ic_inv;
  assign DC_INV_OUT = state_reg.route.dc_inv;
  assign DPOL_OUT = state_reg.dpol;
  assign IPOL_OUT = state_reg.ipol;

  // ==========================================================
  // Checks.
  property p_merge_hit;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN == `DWCP_SPACE_DATA && DC_EN_IN &&
     DC_HIT_IN && state_reg.dpol == `DWCP_DPOL_MERGE)
    |=> (DC_UPD_OUT && DC_DIRTY_OUT && !MEM_WR_OUT);
  endproperty
  a_merge_hit: assert property (p_merge_hit) else $error("merge hit misrouted"); // [RULE_01]

  property p_thru_hit;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN == `DWCP_SPACE_DATA && DC_EN_IN &&
     DC_HIT_IN && state_reg.dpol == `DWCP_DPOL_THRU)
    |=> (DC_UPD_OUT && MEM_WR_OUT && !DC_DIRTY_OUT);
  endproperty
  a_thru_hit: assert property (p_thru_hit) else $error("write-through hit misrouted"); // [RULE_02]

  property p_bypass;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN == `DWCP_SPACE_DATA &&
     state_reg.dpol == `DWCP_DPOL_BYPASS) |=> (MEM_WR_OUT && !DC_UPD_OUT);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass touched data cache"); // [RULE_03]

  property p_dc_off;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN == `DWCP_SPACE_DATA && !DC_EN_IN)
    |=> (MEM_WR_OUT && !DC_UPD_OUT && !DC_DIRTY_OUT);
  endproperty
  a_dc_off: assert property (p_dc_off) else $error("disabled data cache written"); // [RULE_04]

  property p_download;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && REQ_DOWNLOAD_IN) |=> (MEM_WR_OUT && !DC_UPD_OUT && !IC_UPD_OUT
      && IC_INV_OUT == $past(IC_HIT_IN) && DC_INV_OUT == $past(DC_HIT_IN));
  endproperty
  a_download: assert property (p_download) else $error("download misrouted"); // [RULE_05]

  property p_untyped;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN == `DWCP_SPACE_NONE)
    |=> (MEM_WR_OUT && !DC_DIRTY_OUT);
  endproperty
  a_untyped: assert property (p_untyped) else $error("untyped write not instruction"); // [RULE_06]

  property p_both_off;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && !IC_EN_IN &&
     !DC_EN_IN) |=> (MEM_WR_OUT && !DC_UPD_OUT && !IC_UPD_OUT && !IC_INV_OUT);
  endproperty
  a_both_off: assert property (p_both_off) else $error("caches off but touched"); // [RULE_07]

  property p_ic_off;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && !IC_EN_IN)
    |=> (MEM_WR_OUT && !IC_UPD_OUT && !IC_INV_OUT);
  endproperty
  a_ic_off: assert property (p_ic_off) else $error("disabled icache touched"); // [RULE_08]

  property p_upd_dcb;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && IC_EN_IN &&
     IC_HIT_IN && state_reg.ipol == `DWCP_IPOL_UPD_DCB) |=> (IC_UPD_OUT && MEM_WR_OUT
      && !DC_UPD_OUT);
  endproperty
  a_upd_dcb: assert property (p_upd_dcb) else $error("upd_dcb misrouted"); // [RULE_09]

  property p_upd_dcu;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && IC_EN_IN &&
     DC_EN_IN && IC_HIT_IN && DC_HIT_IN && state_reg.ipol == `DWCP_IPOL_UPD_DCU)
    |=> (IC_UPD_OUT && DC_UPD_OUT && MEM_WR_OUT);
  endproperty
  a_upd_dcu: assert property (p_upd_dcu) else $error("upd_dcu misrouted"); // [RULE_10]

  property p_inv_dcb;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && IC_EN_IN &&
     IC_HIT_IN && state_reg.ipol == `DWCP_IPOL_INV_DCB) |=> (IC_INV_OUT && !IC_UPD_OUT
      && MEM_WR_OUT && !DC_UPD_OUT);
  endproperty
  a_inv_dcb: assert property (p_inv_dcb) else $error("inv_dcb misrouted"); // [RULE_11]

  property p_inv_dcu;
    @(posedge CLK_IN) disable iff (RST_IN)
    (REQ_VALID_IN && !REQ_DOWNLOAD_IN && REQ_SPACE_IN != `DWCP_SPACE_DATA && IC_EN_IN &&
     DC_EN_IN && IC_HIT_IN && DC_HIT_IN && state_reg.ipol == `DWCP_IPOL_INV_DCU)
    |=> (IC_INV_OUT && DC_UPD_OUT && MEM_WR_OUT);
  endproperty
  a_inv_dcu: assert property (p_inv_dcu) else $error("inv_dcu misrouted"); // [RULE_12]

  property p_reset_pol;
    @(posedge CLK_IN) $fell(RST_IN) |-> (DPOL_OUT == `DWCP_DPOL_RESET &&
      IPOL_OUT == `DWCP_IPOL_RESET);
  endproperty
  a_reset_pol: assert property (p_reset_pol) else $error("policy reset value wrong"); // [RULE_14]

  property p_cov_merge;
    @(posedge CLK_IN) disable iff (RST_IN) DC_DIRTY_OUT;
  endproperty
  c_cov_merge: cover property (p_cov_merge);

  property p_cov_inv;
    @(posedge CLK_IN) disable iff (RST_IN) IC_INV_OUT && DC_UPD_OUT;
  endproperty
  c_cov_inv: cover property (p_cov_inv);

  property p_cov_dl;
    @(posedge CLK_IN) disable iff (RST_IN) DC_INV_OUT && IC_INV_OUT;
  endproperty
  c_cov_dl: cover property (p_cov_dl);
endmodule
`default_nettype wire

// file: dwcp_defs.svh
`ifndef DWCP_DEFS_SVH
`define DWCP_DEFS_SVH
// Data-write policy codes.
`define DWCP_DPOL_MERGE 2'h0
`define DWCP_DPOL_THRU 2'h1
`define DWCP_DPOL_BYPASS 2'h2
// Instruction-write policy codes.
`define DWCP_IPOL_UPD_DCB 2'h0
`define DWCP_IPOL_UPD_DCU 2'h1
`define DWCP_IPOL_INV_DCB 2'h2
`define DWCP_IPOL_INV_DCU 2'h3
// Reset values of the policy selections.
`define DWCP_DPOL_RESET 2'h0
`define DWCP_IPOL_RESET 2'h1
// Space codes of a write request.
`define DWCP_SPACE_NONE 2'h0
`define DWCP_SPACE_INSTR 2'h1
`define DWCP_SPACE_DATA 2'h2
`endif

// file: dwcp_pkg.sv
`default_nettype none
package dwcp_pkg;
  typedef struct packed {
    logic mem_wr;
    logic dc_upd;
    logic dc_dirty;
    logic ic_upd;
    logic ic_inv;
    logic dc_inv;
  } dwcp_route_type;
endpackage
`default_nettype wire

// file: dwcp_route_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dwcp_route_if;
  logic is_instr;
  logic download;
  logic ic_hit;
  logic dc_hit;
  logic ic_en;
  logic dc_en;
  logic [1:0] dpol;
  logic [1:0] ipol;
  dwcp_pkg::dwcp_route_type route;
  modport ctl (output is_instr, download, ic_hit, dc_hit, ic_en, dc_en, dpol, ipol,
    input route);
  modport dec (input is_instr, download, ic_hit, dc_hit, ic_en, dc_en, dpol, ipol,
    output route);
endinterface
`default_nettype wire

// file: dwcp_decode.sv
`timescale 1ns/1ps
`default_nettype none
`include "dwcp_defs.svh"
module dwcp_decode (
  dwcp_route_if.dec rif
);
  always_comb begin
    rif.route = '0;
    if (rif.download) begin
      rif.route.mem_wr = 1'b1; // [RULE_05]
      rif.route.ic_inv = rif.ic_hit; // [RULE_05]
      rif.route.dc_inv = rif.dc_hit; // [RULE_05]
    end else if (!rif.is_instr) begin
      rif.route.mem_wr = 1'b1;
      if (rif.dc_en && rif.dc_hit) begin // [RULE_04]
        unique case (rif.dpol)
          `DWCP_DPOL_MERGE: begin
            rif.route.mem_wr = 1'b0; // [RULE_01]
            rif.route.dc_upd = 1'b1; // [RULE_01]
            rif.route.dc_dirty = 1'b1; // [RULE_01]
          end
          `DWCP_DPOL_THRU: rif.route.dc_upd = 1'b1; // [RULE_02]
          default: rif.route.dc_upd = 1'b0; // [RULE_03]
        endcase
      end
    end else begin
      // Instruction writes always reach memory so the processor fetches new code.
      rif.route.mem_wr = 1'b1;
      if (rif.ic_en || rif.dc_en) begin // [RULE_07]
        if (rif.ic_en && rif.ic_hit) begin // [RULE_08]
          rif.route.ic_upd = (rif.ipol == `DWCP_IPOL_UPD_DCB) ||
            (rif.ipol == `DWCP_IPOL_UPD_DCU); // [RULE_09] [RULE_10]
          rif.route.ic_inv = (rif.ipol == `DWCP_IPOL_INV_DCB) ||
            (rif.ipol == `DWCP_IPOL_INV_DCU); // [RULE_11] [RULE_12]
        end
        rif.route.dc_upd = rif.dc_en && rif.dc_hit &&
          ((rif.ipol == `DWCP_IPOL_UPD_DCU) || (rif.ipol == `DWCP_IPOL_INV_DCU)); // [RULE_10] [RULE_12]
      end
    end
  end
endmodule
`default_nettype wire

// file: dwcp_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dwcp_mem_model (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Routing result from the policy block.
  input wire logic route_valid_in,
  input wire logic mem_wr_in,
  input wire logic dc_dirty_in,
  input wire logic dc_inv_in,
  // Observed state.
  output logic [15:0] mem_count_out,
  output logic line_dirty_out
);
  // ==========================================================
  // Memory and single data line
  // A dirty line left behind a bypassing write would later overwrite memory.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mem_count_out <= 16'h0000;
      line_dirty_out <= 1'h0;
    end else if (route_valid_in) begin
      if (mem_wr_in) begin
        mem_count_out <= mem_count_out + 16'h0001;
      end
      if (dc_inv_in) begin
        line_dirty_out <= 1'h0;
      end else if (dc_dirty_in) begin
        line_dirty_out <= 1'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: dwcp_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dwcp_top_tb;
  typedef struct packed {
    logic [1:0] space;
    logic dl;
    logic ice;
    logic dce;
    logic ich;
    logic dch;
    logic [1:0] dpol;
    logic [1:0] ipol;
    logic [5:0] exp;
  } dwcp_row_type;
  logic clk, rst, cfg_we, ic_en, dc_en, req_valid, req_dl, ic_hit, dc_hit;
  logic [1:0] cfg_dpol, cfg_ipol, req_space, dpol, ipol;
  wire [6:0] route;
  logic [5:0] want;
  logic [15:0] mem_count;
  logic line_dirty;
  int fail_count, comparisons, mem_exp;
  dwcp_row_type rows[17];
  dwcp_top u_dwcp_top (.CLK_IN(clk), .RST_IN(rst), .CFG_WE_IN(cfg_we), .CFG_DPOL_IN(cfg_dpol),
    .CFG_IPOL_IN(cfg_ipol), .IC_EN_IN(ic_en), .DC_EN_IN(dc_en), .REQ_VALID_IN(req_valid),
    .REQ_SPACE_IN(req_space), .REQ_DOWNLOAD_IN(req_dl), .IC_HIT_IN(ic_hit), .DC_HIT_IN(dc_hit),
    .ROUTE_VALID_OUT(route[6]), .MEM_WR_OUT(route[5]), .DC_UPD_OUT(route[4]),
    .DC_DIRTY_OUT(route[3]), .IC_UPD_OUT(route[2]), .IC_INV_OUT(route[1]),
    .DC_INV_OUT(route[0]), .DPOL_OUT(dpol), .IPOL_OUT(ipol));
  dwcp_mem_model u_dwcp_mem_model (.clk_in(clk), .rst_in(rst), .route_valid_in(route[6]),
    .mem_wr_in(route[5]), .dc_dirty_in(route[3]), .dc_inv_in(route[0]),
    .mem_count_out(mem_count), .line_dirty_out(line_dirty));
  // ==========================================================
  // Shared tasks
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Drives one request cycle; the caller lowers the strobe or sends another.
  task automatic send(input dwcp_row_type r);
    req_valid = 1'h1;
    req_space = r.space;
    req_dl = r.dl;
    ic_en = r.ice;
    dc_en = r.dce;
    ic_hit = r.ich;
    dc_hit = r.dch;
    @(posedge clk);
    #1;
  endtask
  task automatic set_policy(input logic [1:0] dp, input logic [1:0] ip);
    cfg_we = 1'h1;
    cfg_dpol = dp;
    cfg_ipol = ip;
    @(posedge clk);
    #1;
    cfg_we = 1'h0;
  endtask
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    fail_count++;
    finish_test();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {cfg_we, ic_en, dc_en, req_valid, req_dl, ic_hit, dc_hit} = 7'h00;
    {cfg_dpol, cfg_ipol, req_space} = 6'h00;
    fail_count = 0;
    comparisons = 0;
    rst = 1'h1;
    rows[0] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h1, 6'h18};
    rows[1] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 2'h0, 2'h1, 6'h20};
    rows[2] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h1, 2'h1, 6'h30};
    rows[3] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 2'h1, 2'h1, 6'h20};
    rows[4] = '{2'h2, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h2, 2'h1, 6'h20};
    rows[5] = '{2'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 2'h0, 2'h1, 6'h20};
    rows[6] = '{2'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h1, 6'h23};
    rows[7] = '{2'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1, 2'h0, 2'h1, 6'h23};
    rows[8] = '{2'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h0, 6'h24};
    rows[9] = '{2'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h1, 6'h34};
    rows[10] = '{2'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h2, 6'h22};
    rows[11] = '{2'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h3, 6'h32};
    rows[12] = '{2'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h2, 6'h22};
    rows[13] = '{2'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 2'h0, 2'h1, 6'h20};
    rows[14] = '{2'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 2'h1, 6'h30};
    rows[15] = '{2'h1, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 2'h0, 6'h20};
    rows[16] = '{2'h3, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 2'h0, 2'h3, 6'h32};
    repeat (8) @(posedge clk);
    #1;
    check("reset policies", {12'h000, dpol, ipol}, 16'h0001);
    rst = 1'h0;
    mem_exp = 0;
    foreach (rows[i]) begin
      want = rows[i].exp;
      set_policy(rows[i].dpol, rows[i].ipol);
      send(rows[i]);
      req_valid = 1'h0;
      check("valid", 16'(route[6]), 16'h0001);
      check("mem wr", 16'(route[5]), 16'(want[5]));
      check("dc upd", 16'(route[4]), 16'(want[4]));
      check("dirty", 16'(route[3]), 16'(want[3]));
      check("ic upd", 16'(route[2]), 16'(want[2]));
      check("ic inv", 16'(route[1]), 16'(want[1]));
      check("dc inv", 16'(route[0]), 16'(want[0]));
      mem_exp += want[5];
    end
    // The memory model counts a write one edge after the route appears.
    @(posedge clk);
    #1;
    check("memory writes", mem_count, mem_exp[15:0]);
    $display("table test done");
    // A refused data code keeps the old one while the instruction code still loads.
    set_policy(2'h1, 2'h3);
    @(posedge clk);
    #1;
    set_policy(2'h3, 2'h0);
    check("refused code", {12'h000, dpol, ipol}, 16'h0004);
    @(posedge clk);
    #1;
    // Back to back: a policy write in the request cycle must not affect that request.
    cfg_we = 1'h1;
    cfg_dpol = 2'h0;
    cfg_ipol = 2'h1;
    @(posedge clk);
    #1;
    cfg_dpol = 2'h1;
    send(rows[0]);
    cfg_we = 1'h0;
    check("old policy used", {9'h000, route}, 16'h0058);
    check("policy loaded", {12'h000, dpol, ipol}, 16'h0005);
    send(rows[6]);
    req_valid = 1'h0;
    check("download", {9'h000, route}, 16'h0063);
    check("dirty line", {15'h0000, line_dirty}, 16'h0001);
    @(posedge clk);
    #1;
    check("idle route", {9'h000, route}, 16'h0000);
    check("line dropped", {15'h0000, line_dirty}, 16'h0000);
    rst = 1'h1;
    #3;
    check("mid reset", {12'h000, dpol, ipol}, 16'h0001);
    @(posedge clk);
    #1;
    rst = 1'h0;
    // The first request may follow the release at once and must see the reset policies.
    send(rows[0]);
    req_valid = 1'h0;
    check("first after reset", {9'h000, route}, 16'h0058);
    $display("hand tests done");
    finish_test();
  end
endmodule
`default_nettype wire
